// [hw/sdc_pkg.sv]
/*
 Constants for the converter channel register block: map, fields, resets.
 Assumes a 16-bit register port with byte offsets and one 40 MHz clock.
*/
package sdc_pkg;
   // Sizes
   localparam int N_CH = 3;
   localparam int AW = 8;
   localparam int DW = 16;
   localparam int FW = 32;
   localparam int CH_SHIFT = 4;
   // Register offsets inside a channel block, and the shared enable register
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_INCTL = 4'h4;
   localparam logic [3:0] OFS_RESULT = 4'h8;
   localparam logic [3:0] OFS_PRELOAD = 4'hC;
   localparam logic [AW-1:0] OFS_AE = 8'h40;
   // Channel control fields
   localparam int CTRL_GRP = 0;
   localparam int CTRL_START = 1;
   localparam int CTRL_FLAG = 2;
   localparam int CTRL_LOW = 6;
   // Input control fields
   localparam int DLY_LSB = 6;
   localparam int GAIN_LSB = 3;
   localparam int PAIR_LSB = 0;
   // Reset values
   localparam logic [7:0] RST_INCTL = 8'h00;
   localparam logic [7:0] RST_PRELOAD = 8'h00;
   localparam logic [7:0] RST_AE = 8'h00;
   // Highest legal gain code (x32) and the input pairs this variant has
   localparam logic [2:0] GAIN_MAX = 3'h5;
   localparam logic [7:0] PAIR_AVAIL = 8'hFF;
   // Samples skipped before the first result with delay code 00
   localparam logic [1:0] SKIP_MAX = 2'h3;
endpackage

// [hw/sdc_chan_if.sv]
/*
 Carrier between the register block and one channel's sample gate.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sdc_chan_if;
   import sdc_pkg::*;
   logic start; // Conversion start pulse
   logic [1:0] dly; // First result delay code
   logic sample; // Filter sample strobe, gated by run
   logic [FW-1:0] fdata; // Filter output
   logic capture; // New result captured
   logic [FW-1:0] result; // Held filter output
   modport ctl (output start, dly, sample, fdata, input capture, result);
   modport gate (input start, dly, sample, fdata, output capture, result);
endinterface

// [hw/sdc_sample_gate.sv]
/*
 Per-channel sample gate: drops the first samples after a start, then
 captures each filter word. Assumes samples arrive only while running.
*/
`timescale 1ns/1ps
module sdc_sample_gate
   import sdc_pkg::*;
(
   input wire logic ref_clk_i, // 40 MHz clock
   input wire logic rst_n_i, // Sync reset, low
   sdc_chan_if.gate ch // Channel link
);
   logic [1:0] skip;
   logic next_capture;
   logic dec;

   // Capture once the skip count is used up; a start reloads it
   assign next_capture = ch.sample & ~ch.start & (skip == 2'h0);
   assign dec = ch.sample & ~ch.start & (skip != 2'h0);

   // Skip counter, capture strobe and result hold
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         skip <= 2'h0;
         ch.capture <= 1'b0;
         ch.result <= '0;
      end else begin
         ch.capture <= next_capture;
         if (ch.start) begin
            skip <= SKIP_MAX - ch.dly;
         end else if (dec) begin
            skip <= skip - 2'h1;
         end
         if (next_capture) begin
            ch.result <= ch.fdata;
         end
      end
   end

   a_delay_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ch.start |=> skip == SKIP_MAX - $past(ch.dly))
      else $error("skip count not loaded from delay code");
   a_skip_blocks: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ch.sample && skip != 2'h0) |=> !ch.capture)
      else $error("sample captured while still skipping");
   c_first_capture: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      ch.start ##[1:40] ch.capture);
endmodule // sdc_sample_gate

// [hw/sdc_channel_regs.sv]
/*
 Converter channel registers: control, input control, result window,
 filter preload and analog input enable, behind a plain register port.
 Assumes the filter supplies one sample strobe and word per channel on
 the same clock, and a master that never asserts both strobes at once.
*/
// Design decisions made here: the plain strobed port and the register addresses.
// Operation
// - New result sets the conversion ready flag
// - Reading the result clears the flag
// - Software writes the flag directly
// - Group bit links channel to next one
// - Group bit of last channel does nothing
// - Result shows upper or lower filter half
// - Only available input pairs are kept
`timescale 1ns/1ps
module sdc_channel_regs
   import sdc_pkg::*;
(
   input wire logic ref_clk_i, // 40 MHz clock
   input wire logic rst_n_i, // Sync reset, low
   input wire logic [AW-1:0] addr_i, // Register byte address
   input wire logic [DW-1:0] wdata_i, // Write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   output logic [DW-1:0] rdata_o, // Read data, cycle after read
   input wire logic [N_CH-1:0] sample_i, // Filter sample strobes
   input wire logic [N_CH-1:0][FW-1:0] filt_data_i, // Filter outputs
   output logic [N_CH-1:0] conv_start_o, // Start pulse per channel
   output logic [N_CH-1:0] conv_run_o, // Start bit per channel
   output logic [N_CH-1:0] group_link_o, // Channel linked upward
   output logic [N_CH-1:0] ready_flag_o, // Conversion ready flag
   output logic [N_CH-1:0][2:0] gain_sel_o, // Legal gain code
   output logic [N_CH-1:0][2:0] pair_sel_o, // Input pair code
   output logic [N_CH-1:0][7:0] filter_preload_o, // Filter seed value
   output logic [7:0] analog_pin_enable_o // Analog pin enables
);
   logic [N_CH-1:0] ch_hit;
   logic [N_CH-1:0] ctrl_wr;
   logic [N_CH-1:0] inctl_wr;
   logic [N_CH-1:0] pre_wr;
   logic [N_CH-1:0] res_rd;
   logic [N_CH-1:0] own_start;
   logic [N_CH-1:0] own_stop;
   logic [N_CH-1:0] next_start;
   logic [N_CH-1:0] next_stop;
   logic [N_CH-1:0] capture;
   logic [N_CH-1:0] low_sel;
   logic [N_CH-1:0][7:0] inctl;
   logic [N_CH-1:0][FW-1:0] result;
   logic [N_CH-1:0][DW-1:0] ch_word;
   logic [DW-1:0] rd_word;
   logic ae_hit;
   logic reg_ctrl;
   logic reg_inctl;
   logic reg_res;
   logic reg_pre;
   logic start_wr;
   logic [2:0] wr_gain;
   logic [2:0] wr_pair;
   logic [2:0] next_gain;
   logic [2:0] next_pair;

   // Address decode: channel blocks by high nibble, register by low nibble
   assign reg_ctrl = addr_i[3:0] == OFS_CTRL;
   assign reg_inctl = addr_i[3:0] == OFS_INCTL;
   assign reg_res = addr_i[3:0] == OFS_RESULT;
   assign reg_pre = addr_i[3:0] == OFS_PRELOAD;
   assign ae_hit = addr_i == OFS_AE;
   assign start_wr = wdata_i[CTRL_START];

   // Write value cleaning for gain and input pair
   assign wr_gain = wdata_i[GAIN_LSB +: 3];
   assign wr_pair = wdata_i[PAIR_LSB +: 3];
   assign next_gain = (wr_gain > GAIN_MAX) ? 3'h0 : wr_gain;
   assign next_pair = PAIR_AVAIL[wr_pair] ? wr_pair : 3'h0;

   // Start and stop ripple upward through linked channels
   always_comb begin
      next_start = '0;
      next_stop = '0;
      for (int j = 0; j < N_CH; j++) begin
         next_start[j] = own_start[j];
         next_stop[j] = own_stop[j];
         if (j > 0) begin
            next_start[j] = own_start[j] | (group_link_o[j-1] & next_start[j-1]);
            next_stop[j] = own_stop[j] | (group_link_o[j-1] & next_stop[j-1]);
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < N_CH; g++) begin : g_ch
         sdc_chan_if cif ();

         // Per-channel strobes
         assign ch_hit[g] = addr_i[AW-1:CH_SHIFT] == (AW-CH_SHIFT)'(g);
         assign ctrl_wr[g] = wr_i & ch_hit[g] & reg_ctrl;
         assign inctl_wr[g] = wr_i & ch_hit[g] & reg_inctl;
         assign pre_wr[g] = wr_i & ch_hit[g] & reg_pre;
         assign res_rd[g] = rd_i & ch_hit[g] & reg_res;
         assign own_start[g] = ctrl_wr[g] & start_wr;
         assign own_stop[g] = ctrl_wr[g] & ~start_wr;

         // Link to the sample gate
         assign cif.start = conv_start_o[g];
         assign cif.dly = inctl[g][DLY_LSB +: 2];
         assign cif.sample = sample_i[g] & conv_run_o[g];
         assign cif.fdata = filt_data_i[g];
         assign capture[g] = cif.capture;
         assign result[g] = cif.result;

         sdc_sample_gate u_gate (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .ch(cif.gate)
         );

         // Read word of this channel
         assign ch_word[g] = !ch_hit[g] ? '0 :
            reg_ctrl ? {9'h000, low_sel[g], 3'h0, ready_flag_o[g], conv_run_o[g], group_link_o[g]} :
            reg_inctl ? {8'h00, inctl[g]} :
            reg_res ? (low_sel[g] ? result[g][15:0] : result[g][FW-1:16]) :
            reg_pre ? {8'h00, filter_preload_o[g]} : '0;

         // Control bits: start, group, low half select
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               conv_run_o[g] <= 1'b0;
               conv_start_o[g] <= 1'b0;
               group_link_o[g] <= 1'b0;
               low_sel[g] <= 1'b0;
            end else begin
               conv_start_o[g] <= next_start[g];
               if (next_start[g]) begin
                  conv_run_o[g] <= 1'b1;
               end else if (next_stop[g]) begin
                  conv_run_o[g] <= 1'b0;
               end
               if (ctrl_wr[g]) begin
                  group_link_o[g] <= (g < N_CH - 1) ? wdata_i[CTRL_GRP] : 1'b0;
                  low_sel[g] <= wdata_i[CTRL_LOW];
               end
            end
         end

         // Ready flag: a new result beats both clears
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               ready_flag_o[g] <= 1'b0;
            end else if (capture[g]) begin
               ready_flag_o[g] <= 1'b1;
            end else if (ctrl_wr[g]) begin
               ready_flag_o[g] <= wdata_i[CTRL_FLAG];
            end else if (res_rd[g]) begin
               ready_flag_o[g] <= 1'b0;
            end
         end

         // Input control and preload registers
         always_ff @(posedge ref_clk_i) begin
            if (!rst_n_i) begin
               inctl[g] <= RST_INCTL;
               gain_sel_o[g] <= RST_INCTL[GAIN_LSB +: 3];
               pair_sel_o[g] <= RST_INCTL[PAIR_LSB +: 3];
               filter_preload_o[g] <= RST_PRELOAD;
            end else begin
               if (inctl_wr[g]) begin
                  inctl[g] <= {wdata_i[7:3], next_pair};
                  gain_sel_o[g] <= next_gain;
                  pair_sel_o[g] <= next_pair;
               end
               if (pre_wr[g]) begin
                  filter_preload_o[g] <= wdata_i[7:0];
               end
            end
         end
      end
   endgenerate

   // Merge the channel words and the enable register
   always_comb begin
      rd_word = ae_hit ? {8'h00, analog_pin_enable_o} : '0;
      for (int j = 0; j < N_CH; j++) begin
         rd_word = rd_word | ch_word[j];
      end
   end

   // Read data stands one cycle only; enable register write
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
         analog_pin_enable_o <= RST_AE;
      end else begin
         rdata_o <= rd_i ? rd_word : '0;
         if (wr_i && ae_hit) begin
            analog_pin_enable_o <= wdata_i[7:0];
         end
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_flag_on_result: assert property (capture[0] |=> ready_flag_o[0])
      else $error("result did not raise ready flag");
   a_read_clears: assert property ((res_rd[0] && !capture[0] && !ctrl_wr[0]) |=> !ready_flag_o[0])
      else $error("result read left ready flag set");
   a_flag_write: assert property ((ctrl_wr[0] && !capture[0]) |=>
      ready_flag_o[0] == $past(wdata_i[CTRL_FLAG]))
      else $error("flag write not applied");
   a_group_chain: assert property ((own_start[0] && group_link_o[0]) |=>
      conv_start_o[1] ##1 conv_run_o[1])
      else $error("grouped channel did not start");
   a_last_group: assert property (group_link_o[N_CH-1] == 1'b0)
      else $error("last channel shows group link");
   a_result_half: assert property (res_rd[0] |=> rdata_o ==
      ($past(low_sel[0]) ? $past(result[0][15:0]) : $past(result[0][FW-1:16])))
      else $error("result window shows wrong half");
   a_pair_avail: assert property (PAIR_AVAIL[pair_sel_o[2]])
      else $error("unavailable input pair selected");
   a_start_write: assert property ((ctrl_wr[1] && wdata_i[CTRL_START]) |=>
      conv_start_o[1] ##1 (conv_run_o[1] && !conv_start_o[1]) [*2])
      else $error("start write did not start conversion");
   a_gain_legal: assert property (gain_sel_o[0] <= GAIN_MAX)
      else $error("reserved gain code reached output");
   a_read_once: assert property (!$past(rd_i) |-> rdata_o == '0)
      else $error("read data outside its cycle");

   // Flag only moves for a result, a control write or a result read
   a_flag_holds: assert property ((ready_flag_o[0] && !res_rd[0] && !ctrl_wr[0]) |=>
      ready_flag_o[0])
      else $error("ready flag dropped without a clear");
   a_flag_no_cause: assert property ((!ready_flag_o[0] && !capture[0] && !ctrl_wr[0]) |=>
      !ready_flag_o[0])
      else $error("ready flag rose without a result");
   a_flag_read_bit: assert property ((rd_i && ch_hit[0] && reg_ctrl) |=>
      rdata_o[CTRL_FLAG] == $past(ready_flag_o[0]))
      else $error("control read shows wrong flag");

   // Start, stop and run state of channel 0
   a_start_runs: assert property (own_start[0] |=>
      (conv_start_o[0] && conv_run_o[0]))
      else $error("start write did not run channel");
   a_stop_write: assert property ((ctrl_wr[0] && !wdata_i[CTRL_START]) |=>
      (!conv_run_o[0] && !conv_start_o[0]))
      else $error("zero start bit left channel running");
   a_pulse_cause: assert property (conv_start_o[0] |->
      $past(own_start[0]))
      else $error("start pulse without a start write");
   a_run_holds: assert property ((conv_run_o[0] && !ctrl_wr[0]) |=>
      conv_run_o[0])
      else $error("channel stopped without a write");

   // Grouping, and its absence on the last channel
   a_group_write: assert property (ctrl_wr[0] |=>
      group_link_o[0] == $past(wdata_i[CTRL_GRP]))
      else $error("group bit not stored");
   a_group_stop: assert property ((own_stop[0] && group_link_o[0]) |=>
      !conv_run_o[1])
      else $error("grouped channel did not stop");
   a_ungrouped: assert property ((own_start[0] && !group_link_o[0]) |=>
      !conv_start_o[1])
      else $error("ungrouped channel started");
   a_last_write: assert property (ctrl_wr[N_CH-1] |=>
      !group_link_o[N_CH-1])
      else $error("last channel stored a group bit");

   // Register contents and read words
   a_gain_write: assert property (inctl_wr[0] |=> gain_sel_o[0] ==
      (($past(wdata_i[GAIN_LSB +: 3]) > GAIN_MAX) ? 3'h0 : $past(wdata_i[GAIN_LSB +: 3])))
      else $error("gain code not stored or cleaned");
   a_pair_write: assert property ((inctl_wr[0] && PAIR_AVAIL[wdata_i[PAIR_LSB +: 3]]) |=>
      pair_sel_o[0] == $past(wdata_i[PAIR_LSB +: 3]))
      else $error("available input pair not stored");
   a_preload_write: assert property (pre_wr[0] |=>
      filter_preload_o[0] == $past(wdata_i[7:0]))
      else $error("preload value not stored");
   a_preload_read: assert property ((rd_i && ch_hit[0] && reg_pre) |=>
      rdata_o == {8'h00, $past(filter_preload_o[0])})
      else $error("preload read shows wrong value");
   a_inctl_read: assert property ((rd_i && ch_hit[0] && reg_inctl) |=>
      rdata_o == {8'h00, $past(inctl[0])})
      else $error("input control read shows wrong value");
   a_low_read: assert property ((rd_i && ch_hit[0] && reg_ctrl) |=>
      rdata_o[CTRL_LOW] == $past(low_sel[0]))
      else $error("control read shows wrong half select");
   a_enable_write: assert property ((wr_i && ae_hit) |=>
      analog_pin_enable_o == $past(wdata_i[7:0]))
      else $error("enable value not stored");
   a_unmapped_read: assert property ((rd_i && !ae_hit && ch_hit == '0) |=>
      rdata_o == '0)
      else $error("unmapped read gave data");

   c_group_start: cover property (own_start[0] && group_link_o[0]);
   c_read_clear: cover property (ready_flag_o[0] && res_rd[0]);
   c_set_over_clear: cover property (capture[1] && res_rd[1]);
endmodule // sdc_channel_regs

// [verif/tb.sv]
/*
 Self-checking bench for the converter channel register block.
 Assumes the package constants and a single 40 MHz clock.
*/
`timescale 1ns/1ps
module tb;
   import sdc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [AW-1:0] addr_i = '0;
   logic [DW-1:0] wdata_i = '0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [DW-1:0] rdata_o;
   logic [N_CH-1:0] sample_i = '0;
   logic [N_CH-1:0][FW-1:0] filt_data_i = '0;
   logic [N_CH-1:0] conv_start_o;
   logic [N_CH-1:0] conv_run_o;
   logic [N_CH-1:0] group_link_o;
   logic [N_CH-1:0] ready_flag_o;
   logic [N_CH-1:0][2:0] gain_sel_o;
   logic [N_CH-1:0][2:0] pair_sel_o;
   logic [N_CH-1:0][7:0] filter_preload_o;
   logic [7:0] analog_pin_enable_o;
   int err_count = 0;
   int check_count = 0;
   logic [DW-1:0] rv;
   logic [FW-1:0] fw;

   sdc_channel_regs u_sdc_channel_regs (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i),
      .filt_data_i(filt_data_i), .conv_start_o(conv_start_o), .conv_run_o(conv_run_o),
      .group_link_o(group_link_o), .ready_flag_o(ready_flag_o), .gain_sel_o(gain_sel_o),
      .pair_sel_o(pair_sel_o), .filter_preload_o(filter_preload_o),
      .analog_pin_enable_o(analog_pin_enable_o));

   // Clock, 25 ns period
   always #12.5 ref_clk_i = ~ref_clk_i;

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Register address of a channel
   function automatic logic [AW-1:0] adr(input int c, input logic [3:0] o);
      return AW'(c << CH_SHIFT) | AW'(o);
   endfunction

   // One-cycle write strobe
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   // One-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   // One filter sample on channel 0, then wait out the capture latency
   task automatic samp(input logic [FW-1:0] v);
      @(posedge ref_clk_i);
      sample_i[0] <= 1'b1;
      filt_data_i[0] <= v;
      @(posedge ref_clk_i);
      sample_i[0] <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
   endtask

   // Verdict and end of run
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #(25 * 4000);
      err_count++;
      end_sim();
   end

   // Test sequence
   initial begin
      repeat (3) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      // Reset values and an unmapped place
      rd(OFS_AE, rv);
      chk("enable reset", rv, 32'(RST_AE));
      for (int c = 0; c < N_CH; c++) begin
         rd(adr(c, OFS_INCTL), rv);
         chk("inctl reset", rv, 32'(RST_INCTL));
         rd(adr(c, OFS_PRELOAD), rv);
         chk("preload reset", rv, 32'(RST_PRELOAD));
      end
      wr(8'h34, 16'hFFFF);
      rd(8'h34, rv);
      chk("unmapped", rv, 32'h0);
      // Every gain and pair code, preload values
      for (int g = 0; g < 8; g++) begin
         wr(adr(g % 3, OFS_INCTL), 16'(g * 9));
         rd(adr(g % 3, OFS_INCTL), rv);
         chk("inctl", rv, 32'(g * 9));
         chk("gain", gain_sel_o[g % 3], (g <= GAIN_MAX) ? g : 0);
         chk("pair", pair_sel_o[g % 3], PAIR_AVAIL[g] ? g : 0);
         wr(adr(g % 3, OFS_PRELOAD), 16'(8'hA5 ^ g));
         rd(adr(g % 3, OFS_PRELOAD), rv);
         chk("preload", rv, 32'(8'hA5 ^ g));
         chk("preload out", filter_preload_o[g % 3], 32'(8'hA5 ^ g));
      end
      wr(OFS_AE, 16'h005A);
      rd(OFS_AE, rv);
      chk("enable", rv, 32'h5A);
      chk("enable out", analog_pin_enable_o, 32'h5A);
      // Each delay code, both result halves, flag set and cleared by read
      for (int d = 0; d < 4; d++) begin
         wr(adr(0, OFS_INCTL), 16'(d << DLY_LSB));
         wr(adr(0, OFS_CTRL), 16'((d % 2) << CTRL_LOW | 1 << CTRL_START));
         chk("start pulse", conv_start_o[0], 1);
         for (int s = 0; s <= 3 - d; s++) begin
            chk("flag early", ready_flag_o[0], 0);
            fw = 32'h1234_5678 + 32'(s * 16'h1111 + d);
            samp(fw);
         end
         chk("flag set", ready_flag_o[0], 1);
         rd(adr(0, OFS_CTRL), rv);
         chk("flag bit", rv[CTRL_FLAG], 1);
         rd(adr(0, OFS_RESULT), rv);
         chk("result", rv, (d % 2) ? fw[15:0] : fw[31:16]);
         chk("flag read clear", ready_flag_o[0], 0);
      end
      // Flag cleared by a control write with the flag bit zero
      wr(adr(0, OFS_CTRL), 16'(1 << CTRL_START));
      samp(32'hCAFE_0001);
      chk("flag again", ready_flag_o[0], 1);
      wr(adr(0, OFS_CTRL), 16'(1 << CTRL_START));
      chk("flag write clear", ready_flag_o[0], 0);
      // Start bit zero, grouping and the last channel
      wr(adr(0, OFS_CTRL), 16'h0000);
      chk("stopped", conv_run_o[0], 0);
      chk("no pulse", conv_start_o[0], 0);
      wr(adr(0, OFS_CTRL), 16'(1 << CTRL_GRP));
      chk("link", group_link_o[0], 1);
      wr(adr(0, OFS_CTRL), 16'(1 << CTRL_GRP | 1 << CTRL_START));
      chk("upper run", conv_run_o[1], 1);
      chk("upper pulse", conv_start_o[1], 1);
      wr(adr(0, OFS_CTRL), 16'(1 << CTRL_GRP));
      chk("upper stop", conv_run_o[1], 0);
      wr(adr(0, OFS_CTRL), 16'h0000);
      chk("link cleared", group_link_o[0], 0);
      wr(adr(0, OFS_CTRL), 16'(1 << CTRL_START));
      chk("unlinked", conv_run_o[1], 0);
      chk("unlinked pulse", conv_start_o[1], 0);
      wr(adr(1, OFS_CTRL), 16'(1 << CTRL_START));
      rd(adr(1, OFS_CTRL), rv);
      chk("own run bit", rv[CTRL_START], 1);
      wr(adr(2, OFS_CTRL), 16'(1 << CTRL_GRP));
      chk("last link", group_link_o[2], 0);
      rd(adr(2, OFS_CTRL), rv);
      chk("last group bit", rv[CTRL_GRP], 0);
      end_sim();
   end
endmodule // tb
